// *** verilog/lpc_quant_pkg.sv ***
// Operation
// - One parameter set per 180-sample frame
// - Joint 7-bit pitch code, zero when unvoiced
// - Log pitch quantized to 99 uniform levels
// - Voiced codes avoid weight one and two
// - Received code classed unvoiced, erasure or voiced
// - Voiced: bands two to five thresholded at 0.6
// - Band pattern 0001 is forced to 0000
// - Unvoiced frames carry parity in band slots
// - Unvoiced 13 bits carry Hamming parity
// - Second gain: 32 levels, 10 to 77 dB
// - Zero first gain code decodes to mean
// - Transition first gain: 7 levels, code index+1
// - Spectral vector made monotonic, 50 Hz apart
// - Four-stage vector search, 7/6/6/6 bit indices
// - Weighted error, last two weights scaled down
// - Fourier magnitudes: 8-bit search, fixed weights
// - Aperiodic flag set below 0.5 low band, so always clear when voiced
// - Uniform quantizer thresholds at half steps
package lpc_quant_pkg;
  localparam int FRAME_SAMPLES = 180;
  localparam int VEC_LEN = 10;
  localparam int STAGE_COUNT = 5;
  // Strengths are Q15; 0.6 is 19660.8, so "> 0x4CCC" means "exceeds 0.6"
  localparam logic [15:0] VOICED_LIMIT = 16'h4CCC;
  localparam logic [15:0] APERIODIC_LIMIT = 16'h4000;
  localparam int PITCH_LEVELS = 99;
  localparam int G2_LEVELS = 32;
  localparam int G1_LEVELS = 7;
  // Pitch as log2 in Q12: log2(20) and log2(160)
  localparam logic signed [16:0] PITCH_LOG_LO = 17'sh04527;
  localparam logic signed [16:0] PITCH_LOG_HI = 17'sh07527;
  // Gains in dB, signed Q8
  localparam logic signed [16:0] G2_LO_DB = 17'sh00A00;
  localparam logic signed [16:0] G2_HI_DB = 17'sh04D00;
  localparam logic signed [16:0] G1_FLOOR_DB = 17'sh00600;
  localparam logic signed [16:0] G2_STEADY_DB = 17'sh00500;
  localparam logic signed [16:0] G1_STEADY_DB = 17'sh00300;
  localparam logic [15:0] LSF_MIN_GAP_HZ = 16'h0032;
  localparam logic [15:0] LSF_W9_Q8 = 16'h00A4;
  localparam logic [15:0] LSF_W10_Q8 = 16'h0029;
  localparam logic [15:0] FM_WEIGHT_Q8 [VEC_LEN] = '{16'h0156, 16'h013D, 16'h011B,
    16'h00F5, 16'h00D0, 16'h00AF, 16'h0092, 16'h007A, 16'h0066, 16'h0055};
  localparam logic [3:0] LAST_ELEM = 4'h9;
  localparam logic [3:0] LAST_PASS = 4'h9;
  localparam logic [2:0] LAST_LSF_STAGE = 3'h3;
  localparam logic [2:0] FM_STAGE = 3'h4;
  localparam logic [7:0] LSF1_LAST = 8'h7F;
  localparam logic [7:0] LSFN_LAST = 8'h3F;
  localparam logic [7:0] FM_LAST = 8'hFF;
  localparam int SEARCH_CYCLES_MAX = 6000;
  typedef enum logic [1:0] {
    CLASS_UNVOICED = 2'b00,
    CLASS_ERASURE = 2'b01,
    CLASS_VOICED = 2'b10
  } pitch_class_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SORT = 3'b001,
    ST_SPACE = 3'b010,
    ST_SEARCH = 3'b011,
    ST_NEXT = 3'b100,
    ST_EMIT = 3'b101
  } quant_state_e;
endpackage

// *** verilog/uniform_quantizer.sv ***
`timescale 1ns/1ps
module uniform_quantizer #(
  parameter int LEVELS = 7,
  parameter int IDX_W = 3
) (
  input logic signed [16:0] x,
  input logic signed [16:0] lo,
  input logic signed [16:0] hi,
  output logic [IDX_W-1:0] index
);
  if (LEVELS < 2 || LEVELS > (1 << IDX_W)) begin : g_bad_levels
    $error("uniform_quantizer: LEVELS does not fit IDX_W");
  end
  // Scaled by 2*(n-1) so half-step thresholds need no divider
  localparam logic signed [47:0] SCALE = 48'(2 * (LEVELS - 1));
  wire logic signed [47:0] span = 48'(hi) - 48'(lo);
  wire logic signed [47:0] lhs = SCALE * (48'(x) - 48'(lo));
  always_comb begin
    index = '0;
    for (int i = 0; i < LEVELS - 1; i++) begin
      if (lhs >= 48'(2 * i + 1) * span) begin
        index = index + 1'b1;
      end
    end
  end
endmodule

// *** verilog/pitch_code_map.sv ***
`timescale 1ns/1ps
module pitch_code_map
  import lpc_quant_pkg::*;
(
  input logic [6:0] enc_index,
  output logic [6:0] enc_code,
  input logic [6:0] dec_code,
  output logic [6:0] dec_index,
  output pitch_class_e dec_class
);
  logic [7:0] rank;
  always_comb begin
    rank = '0;
    enc_code = '0;
    dec_index = '0;
    for (int c = 0; c < 128; c++) begin
      if ($countones(7'(c)) >= 3) begin
        if (rank == {1'b0, enc_index}) begin
          enc_code = 7'(c);
        end
        if (7'(c) == dec_code) begin
          dec_index = rank[6:0];
        end
        rank = rank + 8'h01;
      end
    end
  end
  wire logic [2:0] dec_weight = 3'($countones(dec_code));
  assign dec_class = (dec_weight <= 3'd1) ? CLASS_UNVOICED :
                     (dec_weight == 3'd2) ? CLASS_ERASURE : CLASS_VOICED;
endmodule

// *** verilog/lpc_voice_param_quantizer.sv ***
`timescale 1ns/1ps
module lpc_voice_param_quantizer
  import lpc_quant_pkg::*;
(
  input logic core_clk,
  input logic reset,
  input logic sample_valid,
  output logic frame_tick,
  input logic param_valid,
  output logic param_ready,
  input logic [15:0] final_pitch_log,
  input logic [15:0] low_band_voicing_strength,
  input logic [3:0][15:0] bandpass_voicing_strength,
  input logic signed [15:0] first_gain,
  input logic signed [15:0] second_gain,
  input logic [9:0][15:0] lsf_in,
  input logic [9:0][15:0] lsf_power,
  input logic [9:0][15:0] fm_in,
  output logic [2:0] cb_stage,
  output logic [7:0] cb_entry,
  output logic [3:0] cb_elem,
  input logic signed [15:0] cb_value,
  output logic codes_valid,
  output logic out_voiced,
  output logic [6:0] out_pitch_code,
  output logic [3:0] out_bandpass,
  output logic [4:0] out_second_gain,
  output logic [2:0] out_first_gain,
  output logic [6:0] out_lsf1,
  output logic [5:0] out_lsf2,
  output logic [5:0] out_lsf3,
  output logic [5:0] out_lsf4,
  output logic [7:0] out_fm,
  output logic out_aperiodic,
  input logic rx_valid,
  input logic [6:0] rx_pitch_code,
  input logic [2:0] rx_gain_code,
  input logic signed [15:0] rx_g2_cur,
  input logic signed [15:0] rx_g2_prev,
  output logic rx_done,
  output pitch_class_e rx_class,
  output logic [6:0] rx_pitch_index,
  output logic signed [15:0] rx_first_gain
);
  function automatic logic [3:0] hamming_par(input logic [3:0] u);
    return {u[3] ^ u[2] ^ u[0], u[3] ^ u[1] ^ u[0], u[2] ^ u[1] ^ u[0], u[3] ^ u[2] ^ u[1]};
  endfunction

  quant_state_e state, next_state;
  logic [3:0] step, next_step, elem, next_elem;
  logic [2:0] stage, next_stage;
  logic [7:0] entry, next_entry;
  logic [7:0] sample_count;
  logic [15:0] lsf [VEC_LEN];
  logic [15:0] next_lsf [VEC_LEN];
  logic [15:0] wt [VEC_LEN];
  logic [15:0] fm_hold [VEC_LEN];
  logic signed [16:0] tgt [VEC_LEN];
  logic signed [15:0] cand [VEC_LEN];
  logic signed [15:0] bestvec [VEC_LEN];
  logic [47:0] acc, best;
  logic [7:0] best_idx;
  logic [7:0] stage_idx [STAGE_COUNT];
  logic voiced_r, ap_r;
  logic [6:0] pitch_r;
  logic [3:0] bp_r;
  logic [4:0] g2_r;
  logic [2:0] g1_r;
  logic signed [15:0] g2_prev;
  logic [6:0] pitch_index, pitch_enc, dec_index;
  logic [4:0] g2_index;
  logic [2:0] g1_index;
  pitch_class_e dec_class;

  wire logic accept = param_valid && param_ready;
  assign param_ready = (state == ST_IDLE);
  assign cb_stage = stage;
  assign cb_entry = entry;
  assign cb_elem = elem;

  // Frame pacing from the front end's sample strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sample_count <= '0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= sample_valid && (sample_count == 8'(FRAME_SAMPLES - 1));
      if (sample_valid) begin
        sample_count <= (sample_count == 8'(FRAME_SAMPLES - 1)) ? 8'h00 : sample_count + 8'h01;
      end
    end
  end

  // Scalar quantizers work on the accepted parameters directly
  wire logic voiced_now = low_band_voicing_strength > VOICED_LIMIT;
  wire logic [3:0] bp_raw = {bandpass_voicing_strength[0] > VOICED_LIMIT,
                             bandpass_voicing_strength[1] > VOICED_LIMIT,
                             bandpass_voicing_strength[2] > VOICED_LIMIT,
                             bandpass_voicing_strength[3] > VOICED_LIMIT};
  wire logic [3:0] bp_fixed = (bp_raw == 4'b0001) ? 4'b0000 : bp_raw;
  wire logic signed [16:0] g2_in = 17'(second_gain);
  wire logic signed [16:0] g2_old = 17'(g2_prev);
  wire logic signed [16:0] g2_min = (g2_in < g2_old) ? g2_in : g2_old;
  wire logic signed [16:0] g2_max = (g2_in < g2_old) ? g2_old : g2_in;
  wire logic signed [16:0] g2_delta = g2_in - g2_old;
  wire logic signed [16:0] g2_mean = (g2_in + g2_old) >>> 1;
  wire logic signed [16:0] g1_dev = 17'(first_gain) - g2_mean;
  wire logic steady = (g2_delta <= G2_STEADY_DB) && (g2_delta >= -G2_STEADY_DB) &&
                      (g1_dev <= G1_STEADY_DB) && (g1_dev >= -G1_STEADY_DB);

  uniform_quantizer #(.LEVELS(PITCH_LEVELS), .IDX_W(7)) u_pitch_q (
    .x({1'b0, final_pitch_log}),
    .lo(PITCH_LOG_LO),
    .hi(PITCH_LOG_HI),
    .index(pitch_index)
  );
  uniform_quantizer #(.LEVELS(G2_LEVELS), .IDX_W(5)) u_g2_q (
    .x(g2_in),
    .lo(G2_LO_DB),
    .hi(G2_HI_DB),
    .index(g2_index)
  );
  uniform_quantizer #(.LEVELS(G1_LEVELS), .IDX_W(3)) u_g1_q (
    .x(17'(first_gain)),
    .lo(g2_min - G1_FLOOR_DB),
    .hi(g2_max),
    .index(g1_index)
  );
  pitch_code_map u_pitch_map (
    .enc_index(pitch_index),
    .enc_code(pitch_enc),
    .dec_code(rx_pitch_code),
    .dec_index(dec_index),
    .dec_class(dec_class)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      voiced_r <= 1'b0;
      ap_r <= 1'b0;
      pitch_r <= '0;
      bp_r <= '0;
      g2_r <= '0;
      g1_r <= '0;
      g2_prev <= G2_LO_DB[15:0];
    end else if (accept) begin
      voiced_r <= voiced_now;
      pitch_r <= voiced_now ? pitch_enc : 7'h00;
      bp_r <= bp_fixed;
      ap_r <= low_band_voicing_strength < APERIODIC_LIMIT;
      g2_r <= g2_index;
      g1_r <= steady ? 3'b000 : g1_index + 3'd1;
      g2_prev <= second_gain;
    end
  end

  // Control: sort passes, spacing pass, then one search per stage
  wire logic [7:0] last_entry = (stage == 3'h0) ? LSF1_LAST :
                                (stage == FM_STAGE) ? FM_LAST : LSFN_LAST;
  always_comb begin
    next_state = state;
    next_step = step;
    next_stage = stage;
    next_entry = entry;
    next_elem = elem;
    case (state)
      ST_IDLE: begin
        if (param_valid) begin
          next_state = ST_SORT;
          next_step = '0;
        end
      end
      ST_SORT: begin
        next_step = (step == LAST_PASS) ? 4'h1 : step + 4'h1;
        if (step == LAST_PASS) begin
          next_state = ST_SPACE;
        end
      end
      ST_SPACE: begin
        next_step = step + 4'h1;
        if (step == LAST_ELEM) begin
          next_state = ST_SEARCH;
          next_stage = '0;
          next_entry = '0;
          next_elem = '0;
        end
      end
      ST_SEARCH: begin
        next_elem = (elem == LAST_ELEM) ? 4'h0 : elem + 4'h1;
        if (elem == LAST_ELEM) begin
          if (entry == last_entry) begin
            next_state = ST_NEXT;
          end else begin
            next_entry = entry + 8'h01;
          end
        end
      end
      ST_NEXT: begin
        next_entry = '0;
        next_state = (stage == FM_STAGE) ? ST_EMIT : ST_SEARCH;
        if (stage != FM_STAGE) begin
          next_stage = stage + 3'h1;
        end
      end
      ST_EMIT: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      step <= '0;
      stage <= '0;
      entry <= '0;
      elem <= '0;
    end else begin
      state <= next_state;
      step <= next_step;
      stage <= next_stage;
      entry <= next_entry;
      elem <= next_elem;
    end
  end

  // Odd-even transposition sort, then a forward spacing pass; a push past
  // 65535 Hz wraps, which real spectral vectors never approach.
  always_comb begin
    for (int i = 0; i < VEC_LEN; i++) begin
      next_lsf[i] = lsf[i];
    end
    if (state == ST_SORT) begin
      for (int i = 0; i < VEC_LEN - 1; i++) begin
        if (i[0] == step[0] && lsf[i] > lsf[i+1]) begin
          next_lsf[i] = lsf[i+1];
          next_lsf[i+1] = lsf[i];
        end
      end
    end else if (state == ST_SPACE) begin
      if (lsf[step] < lsf[step-4'h1] + LSF_MIN_GAP_HZ) begin
        next_lsf[step] = lsf[step-4'h1] + LSF_MIN_GAP_HZ;
      end
    end
  end

  // Weighted error of one element against the codebook word now read
  wire logic signed [17:0] diff = 18'(tgt[elem]) - 18'(cb_value);
  wire logic [35:0] sq = diff * diff;
  wire logic [51:0] prod = sq * wt[elem];
  wire logic [47:0] acc_sum = acc + 48'(prod[51:8]);
  wire logic [31:0] w9_prod = 32'(lsf_power[8]) * 32'(LSF_W9_Q8);
  wire logic [31:0] w10_prod = 32'(lsf_power[9]) * 32'(LSF_W10_Q8);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < VEC_LEN; i++) begin
        lsf[i] <= '0;
        wt[i] <= '0;
        fm_hold[i] <= '0;
        tgt[i] <= '0;
      end
    end else if (accept) begin
      for (int i = 0; i < VEC_LEN - 2; i++) begin
        wt[i] <= lsf_power[i];
      end
      wt[8] <= w9_prod[23:8];
      wt[9] <= w10_prod[23:8];
      for (int i = 0; i < VEC_LEN; i++) begin
        lsf[i] <= lsf_in[i];
        fm_hold[i] <= fm_in[i];
      end
    end else if (state == ST_SORT || state == ST_SPACE) begin
      for (int i = 0; i < VEC_LEN; i++) begin
        lsf[i] <= next_lsf[i];
        tgt[i] <= 17'(next_lsf[i]);
      end
    end else if (state == ST_NEXT && stage < LAST_LSF_STAGE) begin
      for (int i = 0; i < VEC_LEN; i++) begin
        tgt[i] <= tgt[i] - 17'(bestvec[i]);
      end
    end else if (state == ST_NEXT && stage == LAST_LSF_STAGE) begin
      for (int i = 0; i < VEC_LEN; i++) begin
        tgt[i] <= 17'(fm_hold[i]);
        wt[i] <= FM_WEIGHT_Q8[i];
      end
    end
  end

  // Greedy per-stage search; the first entry of equal error wins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc <= '0;
      best <= '1;
      best_idx <= '0;
      for (int i = 0; i < VEC_LEN; i++) begin
        cand[i] <= '0;
        bestvec[i] <= '0;
      end
      for (int s = 0; s < STAGE_COUNT; s++) begin
        stage_idx[s] <= '0;
      end
    end else if (state == ST_SEARCH) begin
      cand[elem] <= cb_value;
      acc <= (elem == LAST_ELEM) ? 48'h0 : acc_sum;
      if (elem == LAST_ELEM && acc_sum < best) begin
        best <= acc_sum;
        best_idx <= entry;
        for (int i = 0; i < VEC_LEN - 1; i++) begin
          bestvec[i] <= cand[i];
        end
        bestvec[9] <= cb_value;
      end
    end else if (state == ST_NEXT) begin
      stage_idx[stage] <= best_idx;
      best <= '1;
    end
  end

  // Unvoiced frames: parity over first-stage index and both gains
  wire logic [3:0] par_a = hamming_par(stage_idx[0][6:3]);
  wire logic [3:0] par_b = hamming_par({stage_idx[0][2:0], 1'b0});
  wire logic [3:0] par_c = hamming_par(g2_r[4:1]);
  wire logic [3:0] par_d = hamming_par({g2_r[0], g1_r});

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      codes_valid <= 1'b0;
      out_voiced <= 1'b0;
      out_pitch_code <= '0;
      out_bandpass <= '0;
      out_second_gain <= '0;
      out_first_gain <= '0;
      out_lsf1 <= '0;
      out_lsf2 <= '0;
      out_lsf3 <= '0;
      out_lsf4 <= '0;
      out_fm <= '0;
      out_aperiodic <= 1'b0;
    end else begin
      codes_valid <= (state == ST_EMIT);
      if (state == ST_EMIT) begin
        out_voiced <= voiced_r;
        out_pitch_code <= pitch_r;
        out_second_gain <= g2_r;
        out_first_gain <= g1_r;
        out_lsf1 <= stage_idx[0][6:0];
        out_lsf2 <= stage_idx[1][5:0];
        out_lsf3 <= stage_idx[2][5:0];
        out_lsf4 <= stage_idx[3][5:0];
        out_bandpass <= voiced_r ? bp_r : par_a;
        out_fm <= voiced_r ? stage_idx[4] : {par_b[3:1], par_c[3:1], par_d[3:2]};
        out_aperiodic <= voiced_r ? ap_r : par_d[1];
      end
    end
  end

  // Receive side: classify pitch code, rebuild first gain
  wire logic signed [16:0] rx_cur = 17'(rx_g2_cur);
  wire logic signed [16:0] rx_old = 17'(rx_g2_prev);
  wire logic signed [16:0] rx_mean = (rx_cur + rx_old) >>> 1;
  wire logic signed [16:0] rx_lo = ((rx_cur < rx_old) ? rx_cur : rx_old) - G1_FLOOR_DB;
  wire logic signed [16:0] rx_hi = (rx_cur < rx_old) ? rx_old : rx_cur;
  wire logic signed [31:0] rx_ofs = (32'(rx_hi - rx_lo) *
    32'(signed'({1'b0, rx_gain_code - 3'd1}))) / 32'(G1_LEVELS - 1);
  wire logic signed [31:0] rx_level = 32'(rx_lo) + rx_ofs;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_done <= 1'b0;
      rx_class <= CLASS_UNVOICED;
      rx_pitch_index <= '0;
      rx_first_gain <= '0;
    end else begin
      rx_done <= rx_valid;
      if (rx_valid) begin
        rx_class <= dec_class;
        rx_pitch_index <= (dec_class == CLASS_VOICED) ? dec_index : 7'h00;
        rx_first_gain <= (rx_gain_code == 3'b000) ? rx_mean[15:0] : rx_level[15:0];
      end
    end
  end

  // Checks
  logic [12:0] busy_cnt;
  logic lsf_spaced;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= (state == ST_IDLE) ? 13'h0000 : busy_cnt + 13'h0001;
    end
  end
  always_comb begin
    lsf_spaced = 1'b1;
    for (int i = 1; i < VEC_LEN; i++) begin
      if (17'(lsf[i]) < 17'(lsf[i-1]) + 17'(LSF_MIN_GAP_HZ)) begin
        lsf_spaced = 1'b0;
      end
    end
  end

  default clocking cb_main @(posedge core_clk);
  endclocking
  default disable iff (reset);
  sequence accept_s;
    param_valid && param_ready;
  endsequence
  sequence emit_s;
    (state == ST_EMIT) ##1 codes_valid;
  endsequence

  frame_tick_a: assert property (sample_valid && sample_count == 8'(FRAME_SAMPLES - 1)
    |=> frame_tick && sample_count == 8'h00) else $error("frame tick missed");
  voiced_latch_a: assert property (accept_s |=> voiced_r ==
    ($past(low_band_voicing_strength) > VOICED_LIMIT)) else $error("voicing wrong");
  unvoiced_zero_a: assert property (codes_valid && !out_voiced |-> out_pitch_code == 7'h00)
    else $error("unvoiced pitch code not zero");
  pitch_weight_a: assert property (codes_valid && out_voiced |-> $countones(out_pitch_code) >= 3)
    else $error("voiced code uses reserved weight");
  bp_pattern_a: assert property (codes_valid && out_voiced |-> out_bandpass != 4'b0001)
    else $error("band pattern 0001 sent");
  unvoiced_parity_a: assert property (codes_valid && !out_voiced
    |-> out_bandpass == hamming_par(out_lsf1[6:3])) else $error("band parity wrong");
  aperiodic_a: assert property (codes_valid && out_voiced |-> !out_aperiodic)
    else $error("aperiodic set in voiced frame");
  lsf_spacing_a: assert property ((state == ST_SPACE) ##1 (state == ST_SEARCH) |-> lsf_spaced)
    else $error("spectral vector not spaced");
  search_bound_a: assert property (busy_cnt <= 13'(SEARCH_CYCLES_MAX))
    else $error("frame processing too long");
  emit_once_a: assert property (emit_s |=> !codes_valid && param_ready)
    else $error("code strobe longer than one cycle");
  erasure_class_a: assert property (rx_valid && $countones(rx_pitch_code) == 2
    |=> rx_done && rx_class == CLASS_ERASURE) else $error("erasure not flagged");
  rx_mean_a: assert property (rx_valid && rx_gain_code == 3'b000
    |=> rx_first_gain == $past(rx_mean[15:0])) else $error("steady gain not mean");
endmodule

// *** bench/cb_model.sv ***
`timescale 1ns/1ps
module cb_model (
  input wire logic [2:0] cb_stage,
  input wire logic [7:0] cb_entry,
  input wire logic [3:0] cb_elem,
  output logic signed [15:0] cb_value
);
  // Only stage 0 entry 3 is non-zero, so every search result is known in advance
  wire hit = (cb_stage == 3'h0) && (cb_entry == 8'h03);
  wire [15:0] ramp = {12'h000, cb_elem} * 16'h0064 + 16'h0064;
  assign cb_value = hit ? ramp : 16'h0000;
endmodule

// *** bench/lpc_voice_param_quantizer_test.sv ***
`timescale 1ns/1ps
module lpc_voice_param_quantizer_test;
  import lpc_quant_pkg::*;
  logic core_clk, reset, sample_valid, frame_tick, param_valid, param_ready;
  logic [15:0] final_pitch_log, low_band_voicing_strength;
  logic [3:0][15:0] bandpass_voicing_strength;
  logic signed [15:0] first_gain, second_gain, cb_value, rx_g2_cur, rx_g2_prev, rx_first_gain;
  logic [9:0][15:0] lsf_in, lsf_power, fm_in;
  logic [2:0] cb_stage, out_first_gain, rx_gain_code;
  logic [7:0] cb_entry, out_fm;
  logic [3:0] cb_elem, out_bandpass;
  logic codes_valid, out_voiced, out_aperiodic, rx_valid, rx_done;
  logic [6:0] out_pitch_code, out_lsf1, rx_pitch_code, rx_pitch_index;
  logic [4:0] out_second_gain;
  logic [5:0] out_lsf2, out_lsf3, out_lsf4;
  pitch_class_e rx_class;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  lpc_voice_param_quantizer i_lpc_voice_param_quantizer (.core_clk, .reset, .sample_valid,
    .frame_tick, .param_valid, .param_ready, .final_pitch_log, .low_band_voicing_strength,
    .bandpass_voicing_strength, .first_gain, .second_gain, .lsf_in, .lsf_power, .fm_in,
    .cb_stage, .cb_entry, .cb_elem, .cb_value, .codes_valid, .out_voiced, .out_pitch_code,
    .out_bandpass, .out_second_gain, .out_first_gain, .out_lsf1, .out_lsf2, .out_lsf3,
    .out_lsf4, .out_fm, .out_aperiodic, .rx_valid, .rx_pitch_code, .rx_gain_code,
    .rx_g2_cur, .rx_g2_prev, .rx_done, .rx_class, .rx_pitch_index, .rx_first_gain);
  cb_model i_cb_model (.cb_stage, .cb_entry, .cb_elem, .cb_value);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out;
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Three frames at about 5790 cycles each plus the sample run fit well inside
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic run_frame(input logic [15:0] lbv, input logic [15:0] pit,
      input logic [63:0] bps, input logic [15:0] g1, input logic [15:0] g2);
    int n;
    n = 0;
    @(negedge core_clk);
    low_band_voicing_strength = lbv;
    final_pitch_log = pit;
    bandpass_voicing_strength = bps;
    first_gain = g1;
    second_gain = g2;
    param_valid = 1'b1;
    @(negedge core_clk);
    param_valid = 1'b0;
    chk(param_ready, 1'b0, "busy");
    while (codes_valid !== 1'b1 && n < 6000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n[15:0], 16'd5785, "latency");
    chk(out_lsf1, 7'h03, "lsf1");
    chk(out_lsf2, 6'h00, "lsf2");
    chk(out_lsf3, 6'h00, "lsf3");
    chk(out_lsf4, 6'h00, "lsf4");
  endtask

  // Samples come every second cycle, not at 8 kHz, to keep the run short
  task automatic tick_frame;
    for (int i = 0; i < 180; i++) begin
      @(negedge core_clk);
      sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
      if (i < 179) begin
        chk(frame_tick, 1'b0, "early tick");
      end else begin
        chk(frame_tick, 1'b1, "tick");
      end
    end
    @(negedge core_clk);
    chk(frame_tick, 1'b0, "tick width");
  endtask

  task automatic frame_steady;
    run_frame(16'h6000, 16'h4527, {16'h0000, 16'h6000, 16'h0000, 16'h6000}, 16'h0A00,
      16'h0A00);
    chk(out_voiced, 1'b1, "voiced");
    chk(out_pitch_code, 7'h07, "pitch lo");
    chk(out_bandpass, 4'hA, "bands");
    chk(out_second_gain, 5'h00, "g2 lo");
    chk(out_first_gain, 3'h0, "steady");
    chk(out_fm, 8'h00, "fm");
    chk(out_aperiodic, 1'b0, "aperiodic");
  endtask

  task automatic frame_transition;
    run_frame(16'h7FFF, 16'h7527, {16'h7000, 16'h0000, 16'h0000, 16'h0000}, 16'h0400,
      16'h4D00);
    chk(out_pitch_code, 7'h7F, "pitch hi");
    chk(out_bandpass, 4'h0, "band 0001");
    chk(out_second_gain, 5'h1F, "g2 hi");
    chk(out_first_gain, 3'h1, "transition");
  endtask

  // Strength of exactly 0.6 must count as unvoiced
  task automatic frame_unvoiced;
    run_frame(16'h4CCC, 16'h5000, {4{16'h7000}}, 16'h4D00, 16'h4D00);
    chk(out_voiced, 1'b0, "unvoiced");
    chk(out_pitch_code, 7'h00, "pitch zero");
    chk(out_bandpass, 4'h0, "band parity");
    chk(out_fm, 8'hDF, "fm parity");
    chk(out_aperiodic, 1'b0, "flag parity");
  endtask

  task automatic rx_one(input logic [6:0] code, input logic [2:0] gc, input pitch_class_e cls,
      input logic [6:0] idx, input logic [15:0] g1);
    @(negedge core_clk);
    rx_valid = 1'b1;
    rx_pitch_code = code;
    rx_gain_code = gc;
    @(negedge core_clk);
    rx_valid = 1'b0;
    chk(rx_done, 1'b1, "rx done");
    chk(rx_class, cls, "rx class");
    chk(rx_pitch_index, idx, "rx index");
    chk(rx_first_gain, g1, "rx gain");
  endtask

  initial begin
    reset = 1'b1;
    sample_valid = 1'b0;
    param_valid = 1'b0;
    final_pitch_log = 16'h0000;
    low_band_voicing_strength = 16'h0000;
    bandpass_voicing_strength = '0;
    first_gain = 16'h0000;
    second_gain = 16'h0000;
    rx_valid = 1'b0;
    rx_pitch_code = 7'h00;
    rx_gain_code = 3'h0;
    rx_g2_cur = 16'h1400;
    rx_g2_prev = 16'h0A00;
    for (int k = 0; k < 10; k++) begin
      lsf_in[k] = 16'(100 * (k + 1));
      lsf_power[k] = 16'h0100;
      fm_in[k] = 16'h0000;
    end
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    tick_frame();
    frame_steady();
    frame_transition();
    frame_unvoiced();
    rx_one(7'h00, 3'h0, CLASS_UNVOICED, 7'h00, 16'h0F00);
    rx_one(7'h40, 3'h1, CLASS_UNVOICED, 7'h00, 16'h0400);
    rx_one(7'h03, 3'h7, CLASS_ERASURE, 7'h00, 16'h1400);
    rx_one(7'h07, 3'h0, CLASS_VOICED, 7'h00, 16'h0F00);
    rx_one(7'h0B, 3'h0, CLASS_VOICED, 7'h01, 16'h0F00);
    rx_one(7'h13, 3'h0, CLASS_VOICED, 7'h05, 16'h0F00);
    rx_one(7'h7F, 3'h0, CLASS_VOICED, 7'h62, 16'h0F00);
    close_out();
  end
endmodule
